//--- design/pit_pkg.sv
package pit_pkg;

    // control word field positions
    localparam int CTL_SEL_HI  = 7;
    localparam int CTL_SEL_LO  = 6;
    localparam int CTL_ACC_HI  = 5;
    localparam int CTL_ACC_LO  = 4;
    localparam int CTL_MODE_HI = 3;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_BCD_BIT = 0;

    // port select codes
    localparam logic [1:0] PORT_SETUP  = 2'h3;
    localparam logic [1:0] SEL_ILLEGAL = 2'h3;

    // byte access codes
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LSB   = 2'h1;
    localparam logic [1:0] ACC_MSB   = 2'h2;
    localparam logic [1:0] ACC_BOTH  = 2'h3;

    // counter values
    localparam int          NUM_CH    = 3;
    localparam logic [15:0] CNT_CLEAR = 16'h0000;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] CNT_TWO   = 16'h0002;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        PIT_M0,
        PIT_M1,
        PIT_M2,
        PIT_M3,
        PIT_M4,
        PIT_M5
    } pit_mode_type;

    typedef struct packed {
        logic [1:0]   access;
        pit_mode_type mode;
        logic         bcd;
    } pit_setup_type;

    localparam pit_setup_type SETUP_RST = '{access: ACC_LSB, mode: PIT_M0, bcd: 1'b0};

    // host side strobes and data
    typedef struct packed {
        logic       chip_sel_n;
        logic       rd_n;
        logic       wr_n;
        logic [1:0] port_select_lines;
        logic [7:0] data_in;
    } pit_bus_type;

    // mode field: top bit ignored for modes 2 and 3
    function automatic pit_mode_type pit_decode_mode(input logic [2:0] f);
        pit_mode_type m;
        m = PIT_M0;
        case (f)
            3'h0: m = PIT_M0;
            3'h1: m = PIT_M1;
            3'h2, 3'h6: m = PIT_M2;
            3'h3, 3'h7: m = PIT_M3;
            3'h4: m = PIT_M4;
            3'h5: m = PIT_M5;
            default: m = PIT_M0;
        endcase
        return m;
    endfunction : pit_decode_mode

    // one step down, binary or four bcd decades
    function automatic logic [15:0] pit_dec1(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        brw;
        r   = v;
        brw = 1'b1;
        if (!bcd) begin
            r = v - CNT_ONE;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (brw) begin
                    if (v[4*k +: 4] == 4'h0) begin
                        r[4*k +: 4] = 4'h9;
                    end else begin
                        r[4*k +: 4] = v[4*k +: 4] - 4'h1;
                        brw         = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : pit_dec1

endpackage : pit_pkg

//--- design/pit_host_port.sv
`timescale 1ns/100ps
// Behaviour
// - chip select high: data bus floats, strobes ignored, registers kept
// - eight-bit three-state data path for setup words and counts
// - selected write goes to counter 0,1,2 or setup word by port code
// - selected read returns counter 0,1,2; code 3 transfers nothing
// - selected without any strobe low: data bus stays floating
// - counter pick field directs setup word to counter 0,1,2; 3 illegal
// - byte access: latch, low only, high only, low then high
// - mode field decodes six modes, top bit ignored for modes 2 and 3
// - counting format bit picks binary or four-decade bcd counting
// - writing a setup word clears that counter to zero
// - three independent 16-bit down counters with six modes each
// - each counter has own clock and output following its mode
// - gate starts, pauses and resumes counting per mode
// - some modes start counting once the count is fully written
// - latch command captures count for read without disturbing it
// - loaded count of zero counts as 10000H clocks in binary, 10000 clocks in bcd
module pit_host_port
    import pit_pkg::*;
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    // host bus
    input  wire pit_pkg::pit_bus_type        host_bus,
    output logic [7:0]                       data_out,
    output logic                             data_oe_n,
    // counter pins
    input  wire logic [pit_pkg::NUM_CH-1:0]  count_clock_in,
    input  wire logic [pit_pkg::NUM_CH-1:0]  count_enable_in,
    output logic [pit_pkg::NUM_CH-1:0]       timer_wave_pin
);
    import pit_pkg::*;

    pit_setup_type      setup_r      [NUM_CH];
    logic [15:0]        cnt_r        [NUM_CH];
    logic [15:0]        init_r       [NUM_CH];
    logic [15:0]        latch_r      [NUM_CH];
    logic [NUM_CH-1:0]  out_r;
    logic [NUM_CH-1:0]  run_r;
    logic [NUM_CH-1:0]  have_r;
    logic [NUM_CH-1:0]  load_pend_r;
    logic [NUM_CH-1:0]  trig_r;
    logic [NUM_CH-1:0]  latched_r;
    logic [NUM_CH-1:0]  wr_msb_r;
    logic [NUM_CH-1:0]  rd_msb_r;
    logic [NUM_CH-1:0]  clk_prev_r;
    logic [NUM_CH-1:0]  gate_prev_r;
    logic               wr_prev_r;
    logic               rd_act_r;
    logic [1:0]         rd_port_r;
    logic [7:0]         data_out_r;

    // strobe decode
    wire                sel       = !host_bus.chip_sel_n;
    wire [1:0]          port      = host_bus.port_select_lines;
    wire [7:0]          din       = host_bus.data_in;
    wire                wr_fall   = sel && host_bus.rd_n && !host_bus.wr_n && wr_prev_r;
    wire                rd_act    = sel && !host_bus.rd_n && host_bus.wr_n
                                    && (port != PORT_SETUP);
    wire                rd_end    = rd_act_r && !rd_act;
    wire                setup_wr  = wr_fall && (port == PORT_SETUP);
    wire [1:0]          pick      = din[CTL_SEL_HI:CTL_SEL_LO];
    wire [1:0]          new_acc   = din[CTL_ACC_HI:CTL_ACC_LO];
    wire pit_mode_type  new_mode  = pit_decode_mode(din[CTL_MODE_HI:CTL_MODE_LO]);
    wire                new_bcd   = din[CTL_BCD_BIT];
    wire [NUM_CH-1:0]   tick      = count_clock_in & ~clk_prev_r;
    wire [NUM_CH-1:0]   gate_rise = count_enable_in & ~gate_prev_r;

    // read byte selection
    wire [1:0]          rd_ch     = (port == PORT_SETUP) ? 2'h0 : port;
    wire [15:0]         rd_val    = latched_r[rd_ch] ? latch_r[rd_ch] : cnt_r[rd_ch];
    wire [1:0]          rd_acc    = setup_r[rd_ch].access;
    wire                rd_hi     = (rd_acc == ACC_MSB)
                                    || ((rd_acc == ACC_BOTH) && rd_msb_r[rd_ch]);
    wire [7:0]          rd_byte   = rd_hi ? rd_val[15:8] : rd_val[7:0];
    // last byte of a counter read ends
    wire                rd_last   = rd_end && !((setup_r[rd_port_r].access == ACC_BOTH)
                                    && !rd_msb_r[rd_port_r]);

    assign data_out       = data_out_r;
    assign data_oe_n      = !(rd_act && rd_act_r);
    assign timer_wave_pin = out_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_prev_r  <= 1'b1;
            rd_act_r   <= 1'b0;
            rd_port_r  <= 2'h0;
            data_out_r <= BYTE_ZERO;
            for (int i = 0; i < NUM_CH; i++) begin
                setup_r[i]     <= SETUP_RST;
                cnt_r[i]       <= CNT_CLEAR;
                init_r[i]      <= CNT_CLEAR;
                latch_r[i]     <= CNT_CLEAR;
                out_r[i]       <= 1'b0;
                run_r[i]       <= 1'b0;
                have_r[i]      <= 1'b0;
                load_pend_r[i] <= 1'b0;
                trig_r[i]      <= 1'b0;
                latched_r[i]   <= 1'b0;
                wr_msb_r[i]    <= 1'b0;
                rd_msb_r[i]    <= 1'b0;
                // pin held high at release is no edge
                clk_prev_r[i]  <= 1'b1;
                gate_prev_r[i] <= 1'b1;
            end
        end else begin
            wr_prev_r  <= host_bus.wr_n || !sel;
            rd_act_r   <= rd_act;
            rd_port_r  <= port;
            data_out_r <= rd_byte;
            for (int i = 0; i < NUM_CH; i++) begin
                clk_prev_r[i]  <= count_clock_in[i];
                gate_prev_r[i] <= count_enable_in[i];
                // counting, one step per counter clock edge, two steps per edge in mode 3
                if (tick[i]) begin
                    case (setup_r[i].mode)
                        PIT_M0, PIT_M4: begin
                            if (load_pend_r[i] && count_enable_in[i]) begin
                                cnt_r[i]       <= init_r[i];
                                run_r[i]       <= 1'b1;
                                load_pend_r[i] <= 1'b0;
                                out_r[i]       <= (setup_r[i].mode == PIT_M4);
                            end else if (run_r[i] && count_enable_in[i]) begin
                                cnt_r[i] <= pit_dec1(cnt_r[i], setup_r[i].bcd);
                                if (setup_r[i].mode == PIT_M4) begin
                                    out_r[i] <= (cnt_r[i] != CNT_ONE);
                                    if (cnt_r[i] == CNT_ONE) begin
                                        run_r[i] <= 1'b0;
                                    end
                                end else if (cnt_r[i] == CNT_ONE) begin
                                    out_r[i] <= 1'b1;
                                end
                            end else if (setup_r[i].mode == PIT_M4) begin
                                out_r[i] <= 1'b1;
                            end
                        end
                        PIT_M1, PIT_M5: begin
                            if (trig_r[i] && have_r[i]) begin
                                cnt_r[i]  <= init_r[i];
                                run_r[i]  <= 1'b1;
                                trig_r[i] <= 1'b0;
                                out_r[i]  <= (setup_r[i].mode == PIT_M5);
                            end else if (run_r[i]) begin
                                cnt_r[i] <= pit_dec1(cnt_r[i], setup_r[i].bcd);
                                if (cnt_r[i] == CNT_ONE) begin
                                    run_r[i] <= 1'b0;
                                    out_r[i] <= (setup_r[i].mode == PIT_M1);
                                end else begin
                                    out_r[i] <= (setup_r[i].mode == PIT_M5);
                                end
                            end else begin
                                out_r[i] <= 1'b1;
                            end
                        end
                        PIT_M2, PIT_M3: begin
                            if (!count_enable_in[i]) begin
                                out_r[i] <= 1'b1;
                            end else if ((load_pend_r[i] || trig_r[i]) && have_r[i]) begin
                                cnt_r[i]       <= init_r[i];
                                run_r[i]       <= 1'b1;
                                load_pend_r[i] <= 1'b0;
                                trig_r[i]      <= 1'b0;
                                out_r[i]       <= 1'b1;
                            end else if (run_r[i] && setup_r[i].mode == PIT_M2) begin
                                out_r[i] <= (cnt_r[i] != CNT_TWO);
                                cnt_r[i] <= (cnt_r[i] == CNT_ONE) ? init_r[i]
                                          : pit_dec1(cnt_r[i], setup_r[i].bcd);
                            end else if (run_r[i]) begin
                                if (cnt_r[i] == CNT_ONE || cnt_r[i] == CNT_TWO) begin
                                    out_r[i] <= !out_r[i];
                                    cnt_r[i] <= out_r[i]
                                              ? pit_dec1(init_r[i], setup_r[i].bcd)
                                              : init_r[i];
                                end else begin
                                    cnt_r[i] <= pit_dec1(pit_dec1(cnt_r[i], setup_r[i].bcd),
                                                         setup_r[i].bcd);
                                end
                            end
                        end
                        default: begin
                            run_r[i] <= 1'b0;
                        end
                    endcase
                end
                // gate rise after the step, so a new trigger wins over its use
                if (gate_rise[i]) begin
                    trig_r[i] <= 1'b1;
                    if (setup_r[i].mode == PIT_M4 && have_r[i]) begin
                        load_pend_r[i] <= 1'b1;
                    end
                end
                // count value write from the host
                if (wr_fall && port == 2'(i)) begin
                    if (setup_r[i].access == ACC_BOTH && !wr_msb_r[i]) begin
                        init_r[i][7:0] <= din;
                        wr_msb_r[i]    <= 1'b1;
                        if (setup_r[i].mode == PIT_M0) begin
                            run_r[i] <= 1'b0;
                        end
                    end else begin
                        case (setup_r[i].access)
                            ACC_LSB: init_r[i] <= {BYTE_ZERO, din};
                            ACC_MSB: init_r[i] <= {din, BYTE_ZERO};
                            default: init_r[i][15:8] <= din;
                        endcase
                        wr_msb_r[i] <= 1'b0;
                        have_r[i]   <= 1'b1;
                        if (setup_r[i].mode == PIT_M0 || setup_r[i].mode == PIT_M4
                            || !run_r[i]) begin
                            load_pend_r[i] <= 1'b1;
                        end
                    end
                end
                // read completion advances byte order and frees the latch
                if (rd_end && rd_port_r == 2'(i)) begin
                    if (setup_r[i].access == ACC_BOTH && !rd_msb_r[i]) begin
                        rd_msb_r[i] <= 1'b1;
                    end else begin
                        rd_msb_r[i]  <= 1'b0;
                        latched_r[i] <= 1'b0;
                    end
                end
                // setup word or latch command, after the read so a new latch wins
                if (setup_wr && pick == 2'(i) && pick != SEL_ILLEGAL) begin
                    if (new_acc == ACC_LATCH) begin
                        if (!latched_r[i] || (rd_last && rd_port_r == 2'(i))) begin
                            latch_r[i]   <= cnt_r[i];
                            latched_r[i] <= 1'b1;
                        end
                    end else begin
                        setup_r[i]     <= '{access: new_acc, mode: new_mode, bcd: new_bcd};
                        cnt_r[i]       <= CNT_CLEAR;
                        run_r[i]       <= 1'b0;
                        have_r[i]      <= 1'b0;
                        load_pend_r[i] <= 1'b0;
                        trig_r[i]      <= 1'b0;
                        latched_r[i]   <= 1'b0;
                        wr_msb_r[i]    <= 1'b0;
                        rd_msb_r[i]    <= 1'b0;
                        out_r[i]       <= (new_mode != PIT_M0);
                    end
                end
            end
        end
    end

endmodule : pit_host_port

//--- sim/pit_host_port_checker.sv
`timescale 1ns/100ps
module pit_host_port_checker
    import pit_pkg::*;
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    // host bus
    input  wire pit_pkg::pit_bus_type       host_bus,
    input  wire logic [7:0]                 data_out,
    input  wire logic                       data_oe_n,
    // counter pins
    input  wire logic [pit_pkg::NUM_CH-1:0] count_clock_in,
    input  wire logic [pit_pkg::NUM_CH-1:0] count_enable_in,
    input  wire logic [pit_pkg::NUM_CH-1:0] timer_wave_pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    wire sel    = !host_bus.chip_sel_n;
    wire rd_act = sel && !host_bus.rd_n && host_bus.wr_n && host_bus.port_select_lines != 2'h3;
    wire wr_act = sel && host_bus.rd_n && !host_bus.wr_n;

    // setup word write taken for one counter pick
    sequence s_setup(logic [1:0] p);
        wr_act && !$past(wr_act) && host_bus.port_select_lines == PORT_SETUP
            && host_bus.data_in[7:6] == p;
    endsequence

    a_cs_float: assert property (host_bus.chip_sel_n |-> data_oe_n)
        else $error("bus driven while deselected");
    a_idle_float: assert property (sel && host_bus.rd_n && host_bus.wr_n |-> data_oe_n)
        else $error("bus driven without strobe");
    a_port3_quiet: assert property (sel && !host_bus.rd_n && host_bus.wr_n
        && host_bus.port_select_lines == 2'h3 |-> data_oe_n) else $error("setup port driven");
    a_both_low: assert property (sel && !host_bus.rd_n && !host_bus.wr_n |-> data_oe_n)
        else $error("bus driven with both strobes");
    a_write_quiet: assert property (wr_act |-> data_oe_n)
        else $error("bus driven during write");
    a_read_drive: assert property (rd_act ##1 rd_act |-> !data_oe_n)
        else $error("read not driven");
    a_mode0_low: assert property (s_setup(2'h0) ##0 host_bus.data_in[3:1] == 3'h0
        |-> ##[1:4] timer_wave_pin[0] == 1'b0) else $error("mode 0 output not low");
    a_mode2_high: assert property (s_setup(2'h0) ##0 host_bus.data_in[2:1] == 2'h2
        |-> ##[1:4] timer_wave_pin[0]) else $error("mode 2 output not high");
    a_pick_one: assert property (s_setup(2'h1) ##0 host_bus.data_in[3:1] == 3'h1
        |-> ##[1:4] timer_wave_pin[1]) else $error("counter 1 mode 1 output not high");
endmodule : pit_host_port_checker

//--- sim/pit_cpu_model.sv
`timescale 1ns/100ps
module pit_cpu_model
    import pit_pkg::*;
(
    // clock
    input  wire logic           clock,
    // host bus
    output pit_pkg::pit_bus_type host_bus,
    input  wire logic [7:0]     data_out,
    input  wire logic           data_oe_n
);
    initial begin
        host_bus = 13'h1c00;
    end

    // one byte write held across the taking edge
    task automatic wr_byte(input logic [1:0] port, input logic [7:0] d);
        @(negedge clock);
        host_bus.chip_sel_n        = 1'b0;
        host_bus.wr_n              = 1'b0;
        host_bus.port_select_lines = port;
        host_bus.data_in           = d;
        @(negedge clock);
        host_bus.chip_sel_n        = 1'b1;
        host_bus.wr_n              = 1'b1;
        host_bus.data_in           = ~d;
    endtask : wr_byte

    // one byte read, slow stretches the strobe
    task automatic rd_byte(input logic cs_n, input logic [1:0] port, input int slow,
                           output logic [7:0] d, output logic oe_n);
        @(negedge clock);
        host_bus.chip_sel_n        = cs_n;
        host_bus.rd_n              = 1'b0;
        host_bus.port_select_lines = port;
        repeat (2 + slow) @(negedge clock);
        d                          = data_out;
        oe_n                       = data_oe_n;
        host_bus.chip_sel_n        = 1'b1;
        host_bus.rd_n              = 1'b1;
    endtask : rd_byte
endmodule : pit_cpu_model

//--- sim/tb.sv
`timescale 1ns/100ps
module tb;
    import pit_pkg::*;
    logic        clock           = 1'b0;
    logic        sys_rst         = 1'b1;
    pit_bus_type host_bus;
    logic [7:0]  data_out;
    logic        data_oe_n;
    logic [2:0]  count_clock_in  = 3'h0;
    logic [2:0]  count_enable_in = 3'h7;
    logic [2:0]  timer_wave_pin;
    int          mismatches      = 0;
    int          n_checks        = 0;
    logic [7:0]  b0;
    logic        oe;
    logic [15:0] n;
    logic [15:0] e;
    logic [1:0]  acc;
    int          k;

    always #12.5 clock = ~clock;

    pit_host_port DUT (.clock(clock), .sys_rst(sys_rst), .host_bus(host_bus),
        .data_out(data_out), .data_oe_n(data_oe_n), .count_clock_in(count_clock_in),
        .count_enable_in(count_enable_in), .timer_wave_pin(timer_wave_pin));
    pit_cpu_model cpu (.clock(clock), .host_bus(host_bus), .data_out(data_out),
        .data_oe_n(data_oe_n));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic setup(input int ch, input logic [1:0] a, input logic [2:0] m, input logic bcd);
        cpu.wr_byte(PORT_SETUP, {2'(ch), a, m, bcd});
    endtask : setup

    task automatic steps(input int ch, input int cnt);
        repeat (cnt) begin
            @(negedge clock);
            count_clock_in[ch] = 1'b1;
            repeat (2) @(negedge clock);
            count_clock_in[ch] = 1'b0;
            @(negedge clock);
        end
        repeat (3) @(negedge clock);
    endtask : steps

    // count after d down steps, binary or four bcd decades
    function automatic logic [15:0] sub_k(input logic [15:0] v, input int d, input logic bcd);
        int x;
        x = bcd ? (v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]) : int'(v);
        x = x - d;
        if (x < 0) x = x + (bcd ? 10000 : 65536);
        return bcd ? {4'(x / 1000), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)} : 16'(x);
    endfunction : sub_k

    initial begin
        k = $urandom(31866);
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        // every mode code after a mode 0, only mode 0 drives low
        for (int m = 0; m < 17; m++) begin
            setup(0, ACC_LSB, (m % 2) ? 3'(m / 2) : 3'h0, 1'b0);
            repeat (4) @(negedge clock);
            check(16'(timer_wave_pin[0]), 16'((m % 2) && (m / 2) != 0));
        end
        setup(3, ACC_BOTH, 3'h2, 1'b0);
        repeat (4) @(negedge clock);
        check(16'(timer_wave_pin), 16'h0000);
        cpu.rd_byte(1'b1, 2'h0, 0, b0, oe);
        check(16'(oe), 16'h0001);
        cpu.rd_byte(1'b0, 2'h3, 0, b0, oe);
        check(16'(oe), 16'h0001);
        // low only, high only, both in bcd; latch then keep counting
        for (int ch = 0; ch < 3; ch++) begin
            acc = (ch == 0) ? ACC_LSB : (ch == 1) ? ACC_MSB : ACC_BOTH;
            n = (ch == 0) ? {8'h00, 8'($urandom) | 8'h10}
              : (ch == 1) ? {8'($urandom) | 8'h01, 8'h00} : 16'h1234;
            setup(ch, acc, 3'h0, ch == 2);
            if (acc != ACC_MSB) cpu.wr_byte(2'(ch), n[7:0]);
            if (acc != ACC_LSB) cpu.wr_byte(2'(ch), n[15:8]);
            k = 2 + $urandom % 6;
            steps(ch, k);
            setup(ch, ACC_LATCH, 3'h0, 1'b0);
            steps(ch, 2);
            e = sub_k(n, k - 1, ch == 2);
            if (acc != ACC_MSB) cpu.rd_byte(1'b0, 2'(ch), ch, b0, oe);
            if (acc != ACC_MSB) check(16'(b0), 16'(e[7:0]));
            if (acc != ACC_LSB) cpu.rd_byte(1'b0, 2'(ch), ch, b0, oe);
            if (acc != ACC_LSB) check(16'(b0), 16'(e[15:8]));
            // latch freed, counting went on undisturbed
            e = sub_k(n, k + 1, ch == 2);
            if (acc != ACC_MSB) cpu.rd_byte(1'b0, 2'(ch), 0, b0, oe);
            if (acc != ACC_MSB) check(16'(b0), 16'(e[7:0]));
            if (acc != ACC_LSB) cpu.rd_byte(1'b0, 2'(ch), 0, b0, oe);
            if (acc != ACC_LSB) check(16'(b0), 16'(e[15:8]));
            check(16'(oe), 16'h0000);
            check(16'(timer_wave_pin[ch]), 16'h0000);
        end
        // mode 0 terminal count on counter 1
        setup(1, ACC_LSB, 3'h0, 1'b0);
        n = 16'(2 + $urandom % 6);
        cpu.wr_byte(2'h1, n[7:0]);
        steps(1, int'(n));
        check(16'(timer_wave_pin[1]), 16'h0000);
        steps(1, 1);
        check(16'(timer_wave_pin[1]), 16'h0001);
        // mode 1 from a low output: waits for a gate rise, then one shot
        setup(1, ACC_LSB, 3'h0, 1'b0);
        repeat (4) @(negedge clock);
        check(16'(timer_wave_pin[1]), 16'h0000);
        setup(1, ACC_LSB, 3'h1, 1'b0);
        repeat (4) @(negedge clock);
        check(16'(timer_wave_pin[1]), 16'h0001);
        n = 16'(2 + $urandom % 6);
        cpu.wr_byte(2'h1, n[7:0]);
        steps(1, 2);
        check(16'(timer_wave_pin[1]), 16'h0001);
        count_enable_in[1] = 1'b0;
        repeat (2) @(negedge clock);
        count_enable_in[1] = 1'b1;
        steps(1, 1);
        check(16'(timer_wave_pin[1]), 16'h0000);
        steps(1, int'(n));
        check(16'(timer_wave_pin[1]), 16'h0001);
        final_report();
    end

    initial begin
        repeat (4000) @(posedge clock);
        mismatches++;
        final_report();
    end
endmodule : tb

bind pit_host_port pit_host_port_checker u_chk (.clock(clock), .sys_rst(sys_rst),
    .host_bus(host_bus), .data_out(data_out), .data_oe_n(data_oe_n),
    .count_clock_in(count_clock_in), .count_enable_in(count_enable_in),
    .timer_wave_pin(timer_wave_pin));
